// ### hw/gw_fifo_defs.svh
`ifndef GW_FIFO_DEFS_SVH
`define GW_FIFO_DEFS_SVH
// Operation
// RULE_01: with rx enable set, raise rx interrupt when the selected condition is met.
// RULE_02: rx enable per buffer; condition chosen by mode bit and threshold field.
// RULE_03: mode bit one requests rx interrupt on every stored message.
// RULE_04: threshold mode requests when count reaches (code+1)/8 of depth.
// RULE_05: threshold code all ones requests only when buffer becomes full.
// RULE_06: rx request held until software writes zero to rx flag.
// RULE_07: software avoids even threshold codes with four-message depth.
// RULE_08: full enable set raises full interrupt when buffer becomes full.
// RULE_09: disabling usage never clears pending requests; software clears them.
// RULE_10: single frame rx enable raises interrupt on each received frame.
// RULE_11: tx enable with mode one requests on each completed transmission.
// RULE_12: tx enable with mode zero requests when completion leaves buffer empty.
// RULE_13: tx request pending until software writes zero to tx flag.
// RULE_14: single frame tx enable raises interrupt on each transmitted frame.
// RULE_15: fifo lost enable raises global error on message lost in any buffer.
// RULE_16: lost flag and global error persist until software writes zero.
// RULE_17: global error combines seven separately enabled sources; code gates six, history overflow status enters with no enable.
// RULE_18: software selects gateway mode with buffer mode field 10.
// RULE_19: usage disabled stores nothing and buffer reports empty.
// RULE_20: flags stay set until zero written; write one no effect; set wins.
// RULE_21: each interrupt output is flag AND enable; global_error_irq is instead the OR of err_src.

// ****************************************
// constants
// ****************************************
`define NUM_FIFO 2
`define CNT_W 8
`define DEPTH_CODE_W 3
`define THR_W 3
`define THR_FULL 3'h7
`define MODE_GATEWAY 2'h2
`define DEPTH_BASE 8'h04
`define SRC_HIST 0
`define SRC_DLC 1
`define SRC_PAYLOAD 2
`define SRC_QOVW 3
`define SRC_QLOST 4
`define SRC_GWOVW 5
`define SRC_FLOST 6
`define NUM_SRC 7
`endif

// ### hw/gw_fifo_pkg.sv
package gw_fifo_pkg;
  typedef logic [7:0] count_t;
  typedef enum logic [2:0] {
    ST_OFF = 3'h1,
    ST_RUN = 3'h2,
    ST_DRAIN = 3'h4
  } usage_t;
endpackage

// ### hw/sticky_flag.sv
module sticky_flag (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic set,
  input wire logic clear_n,
  output logic flag
);
  // ****************************************
  // sticky flag
  // ****************************************
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      flag <= 1'b0;
    end else if (set) begin
      flag <= 1'b1; // [RULE_20]
    end else if (!clear_n) begin
      flag <= 1'b0; // [RULE_06] [RULE_13] [RULE_16]
    end
  end
endmodule

// ### hw/gw_fifo_irq.sv
`include "gw_fifo_defs.svh"
module gw_fifo_irq (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic [1:0] buffer_mode_field,
  input wire logic buffer_usage_enable,
  input wire logic [2:0] fifo_depth_code,
  input wire logic irq_mode_select,
  input wire logic [2:0] fill_threshold,
  input wire logic rx_irq_enable,
  input wire logic tx_irq_enable,
  input wire logic full_irq_enable,
  input wire logic single_frame_rx_enable,
  input wire logic single_frame_tx_enable,
  input wire logic fifo_lost_enable,
  input wire logic length_code_error_enable,
  input wire logic payload_overwrite_enable,
  input wire logic queue_overwrite_enable,
  input wire logic queue_lost_enable,
  input wire logic gw_fifo_overwrite_enable,
  input wire logic history_overflow_status,
  input wire logic length_code_error_status,
  input wire logic payload_overwrite_status,
  input wire logic queue_overwrite_status,
  input wire logic queue_lost_status,
  input wire logic gw_fifo_overwrite_status,
  input wire logic msg_store,
  input wire logic msg_sent,
  input wire logic msg_lost,
  input wire logic rx_flag_write_n,
  input wire logic tx_flag_write_n,
  input wire logic full_flag_write_n,
  input wire logic frx_flag_write_n,
  input wire logic ftx_flag_write_n,
  input wire logic lost_flag_write_n,
  output gw_fifo_pkg::count_t msg_count,
  output logic fifo_empty,
  output logic fifo_full,
  output logic stored_accept,
  output logic rx_irq_flag,
  output logic tx_irq_flag,
  output logic full_irq_flag,
  output logic frx_irq_flag,
  output logic ftx_irq_flag,
  output logic msg_lost_flag,
  output logic rx_irq,
  output logic tx_irq,
  output logic full_irq,
  output logic single_frame_rx_irq,
  output logic single_frame_tx_irq,
  output logic global_error_irq
);
  import gw_fifo_pkg::*;

  // ****************************************
  // depth and threshold
  // ****************************************
  function automatic count_t depth_of(input logic [2:0] code);
    // code 001 is four messages, each step doubles up to 128 at code 110; code 111 wraps to zero
    depth_of = count_t'(`DEPTH_BASE << (code - 3'h1));
    if (code == 3'h0) begin
      depth_of = count_t'(0);
    end
  endfunction

  function automatic count_t level_of(input logic [2:0] thr, input count_t depth);
    logic [10:0] prod;
    prod = 11'(depth) * 11'({1'b0, thr} + 4'h1);
    level_of = count_t'(prod >> 3); // [RULE_04] [RULE_07]
  endfunction

  count_t depth;
  count_t level;
  usage_t usage;
  logic gateway;
  logic store_ok;
  logic sent_ok;
  logic next_full;
  logic next_empty_after_send;
  logic rx_event;
  logic tx_event;
  logic full_event;

  assign depth = depth_of(fifo_depth_code);
  assign level = level_of(fill_threshold, depth);
  assign gateway = buffer_mode_field == `MODE_GATEWAY;

  // ****************************************
  // usage state
  // ****************************************
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      usage <= ST_OFF;
    end else begin
      case (usage)
        ST_OFF: begin
          if (buffer_usage_enable && gateway) begin
            usage <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (!buffer_usage_enable) begin
            usage <= ST_DRAIN;
          end
        end
        ST_DRAIN: begin
          usage <= ST_OFF;
        end
        default: begin
          usage <= ST_OFF;
        end
      endcase
    end
  end

  // ****************************************
  // fill count
  // ****************************************
  assign store_ok = msg_store && usage == ST_RUN && buffer_usage_enable && !fifo_full; // [RULE_19]
  assign sent_ok = msg_sent && !fifo_empty;
  assign stored_accept = store_ok;
  assign fifo_empty = msg_count == count_t'(0);
  assign fifo_full = depth != count_t'(0) && msg_count >= depth;
  assign next_full = store_ok && !sent_ok && msg_count + count_t'(1) == depth;
  assign next_empty_after_send = sent_ok && !store_ok && msg_count == count_t'(1);

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      msg_count <= count_t'(0);
    end else if (usage != ST_RUN || !buffer_usage_enable) begin
      msg_count <= count_t'(0); // [RULE_19]
    end else if (store_ok && !sent_ok) begin
      msg_count <= msg_count + count_t'(1);
    end else if (sent_ok && !store_ok) begin
      msg_count <= msg_count - count_t'(1);
    end
  end

  // ****************************************
  // event decode
  // ****************************************
  always_comb begin
    full_event = next_full; // [RULE_08]
    if (irq_mode_select) begin
      rx_event = store_ok; // [RULE_03]
      tx_event = sent_ok; // [RULE_11]
    end else begin
      tx_event = next_empty_after_send; // [RULE_12]
      if (fill_threshold == `THR_FULL) begin
        rx_event = next_full; // [RULE_05]
      end else begin
        rx_event = store_ok && !sent_ok && msg_count + count_t'(1) == level; // [RULE_02] [RULE_04]
      end
    end
  end

  // ****************************************
  // status flags
  // ****************************************
  // flags keep their value when usage drops [RULE_09]
  sticky_flag u_rx (.ref_clk(ref_clk), .rstn(rstn), .set(rx_event), .clear_n(rx_flag_write_n), .flag(rx_irq_flag));
  sticky_flag u_tx (.ref_clk(ref_clk), .rstn(rstn), .set(tx_event), .clear_n(tx_flag_write_n), .flag(tx_irq_flag));
  sticky_flag u_full (.ref_clk(ref_clk), .rstn(rstn), .set(full_event), .clear_n(full_flag_write_n),
    .flag(full_irq_flag));
  sticky_flag u_frx (.ref_clk(ref_clk), .rstn(rstn), .set(store_ok), .clear_n(frx_flag_write_n),
    .flag(frx_irq_flag)); // [RULE_10]
  sticky_flag u_ftx (.ref_clk(ref_clk), .rstn(rstn), .set(sent_ok), .clear_n(ftx_flag_write_n),
    .flag(ftx_irq_flag)); // [RULE_14]
  sticky_flag u_lost (.ref_clk(ref_clk), .rstn(rstn), .set(msg_lost && usage == ST_RUN),
    .clear_n(lost_flag_write_n), .flag(msg_lost_flag)); // [RULE_16]

  // ****************************************
  // interrupt outputs
  // ****************************************
  logic [`NUM_SRC-1:0] err_src;
  assign err_src[`SRC_HIST] = history_overflow_status;
  assign err_src[`SRC_DLC] = length_code_error_status && length_code_error_enable;
  assign err_src[`SRC_PAYLOAD] = payload_overwrite_status && payload_overwrite_enable;
  assign err_src[`SRC_QOVW] = queue_overwrite_status && queue_overwrite_enable;
  assign err_src[`SRC_QLOST] = queue_lost_status && queue_lost_enable;
  assign err_src[`SRC_GWOVW] = gw_fifo_overwrite_status && gw_fifo_overwrite_enable;
  assign err_src[`SRC_FLOST] = msg_lost_flag && fifo_lost_enable; // [RULE_15]

  assign rx_irq = rx_irq_flag && rx_irq_enable; // [RULE_01] [RULE_21]
  assign tx_irq = tx_irq_flag && tx_irq_enable; // [RULE_21]
  assign full_irq = full_irq_flag && full_irq_enable; // [RULE_08]
  assign single_frame_rx_irq = frx_irq_flag && single_frame_rx_enable; // [RULE_10]
  assign single_frame_tx_irq = ftx_irq_flag && single_frame_tx_enable; // [RULE_14]
  assign global_error_irq = |err_src; // [RULE_17]
endmodule

// ### verification/gw_fifo_irq_sva.sv
// ********
// checker
// ********
module gw_fifo_irq_sva (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic msg_store,
  input wire logic msg_sent,
  input wire logic stored_accept,
  input wire logic irq_mode_select,
  input wire logic buffer_usage_enable,
  input wire logic fifo_lost_enable,
  input wire logic rx_flag_write_n,
  input wire logic tx_flag_write_n,
  input wire logic lost_flag_write_n,
  input gw_fifo_pkg::count_t msg_count,
  input wire logic fifo_empty,
  input wire logic fifo_full,
  input wire logic rx_irq_flag,
  input wire logic frx_irq_flag,
  input wire logic tx_irq_flag,
  input wire logic full_irq_flag,
  input wire logic msg_lost_flag,
  input wire logic global_error_irq
);
  timeunit 1ns;
  timeprecision 1ns;
  import gw_fifo_pkg::*;
  default clocking dc @(posedge ref_clk);
  endclocking
  default disable iff (!rstn);
  sequence fill_s; stored_accept && !msg_sent; endsequence
  a_frx_set: assert property (stored_accept |=> frx_irq_flag) else $error("frx flag");
  a_rx_each: assert property (stored_accept && irq_mode_select |=> rx_irq_flag) else $error("rx");
  a_rx_held: assert property (rx_irq_flag && rx_flag_write_n |=> rx_irq_flag) else $error("rx hold");
  a_tx_held: assert property (tx_irq_flag && tx_flag_write_n |=> tx_irq_flag) else $error("tx hold");
  a_lost_held: assert property (msg_lost_flag && lost_flag_write_n |=> msg_lost_flag) else $error("lost hold");
  a_tx_each: assert property (msg_sent && !msg_store && !fifo_empty && irq_mode_select |=> tx_irq_flag)
    else $error("tx");
  a_tx_empty: assert property (msg_sent && !msg_store && msg_count == 8'h01 |=> tx_irq_flag) else $error("tx");
  a_full_set: assert property (fill_s ##1 $rose(fifo_full) |-> full_irq_flag) else $error("full");
  a_lost_err: assert property (msg_lost_flag && fifo_lost_enable |-> global_error_irq) else $error("lost");
  a_off_idle: assert property (!buffer_usage_enable |-> !stored_accept) else $error("store off");
endmodule

// ### verification/gw_sw_model.sv
// ********
// software flag clearing
// ********
module gw_sw_model (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic [5:0] clr_req,
  output logic [5:0] wr_n
);
  timeunit 1ns;
  timeprecision 1ns;
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) wr_n <= 6'h3F;
    else wr_n <= ~clr_req;
  end
endmodule

// ### verification/gw_fifo_irq_test.sv
// ********
// bench
// ********
module gw_fifo_irq_test;
  timeunit 1ns;
  timeprecision 1ns;
  import gw_fifo_pkg::*;
  logic ref_clk = 1'h0;
  logic rstn = 1'h0;
  logic [1:0] buffer_mode_field = 2'h2;
  logic buffer_usage_enable = 1'h1;
  logic irq_mode_select = 1'h0;
  logic [2:0] fifo_depth_code = 3'h1;
  logic [2:0] fill_threshold = 3'h3;
  logic [2:0] ev = 3'h0;
  logic [5:0] ien = 6'h3F;
  logic [4:0] gen = 5'h00;
  logic [5:0] gst = 6'h00;
  logic [5:0] clr_req = 6'h00;
  logic [5:0] wr_n;
  int compares = 0;
  int bad_count = 0;
  count_t msg_count;
  logic fifo_empty, fifo_full, stored_accept, rx_irq_flag, tx_irq_flag, full_irq_flag, frx_irq_flag, ftx_irq_flag;
  logic msg_lost_flag, rx_irq, tx_irq, full_irq, single_frame_rx_irq, single_frame_tx_irq, global_error_irq;
  wire msg_store, msg_sent, msg_lost, rx_irq_enable, tx_irq_enable, full_irq_enable, single_frame_rx_enable;
  wire single_frame_tx_enable, fifo_lost_enable, length_code_error_enable, payload_overwrite_enable;
  wire queue_overwrite_enable, queue_lost_enable, gw_fifo_overwrite_enable, history_overflow_status;
  wire length_code_error_status, payload_overwrite_status, queue_overwrite_status, queue_lost_status;
  wire gw_fifo_overwrite_status, rx_flag_write_n, tx_flag_write_n, full_flag_write_n, frx_flag_write_n;
  wire ftx_flag_write_n, lost_flag_write_n;
  assign {msg_lost, msg_sent, msg_store} = ev;
  assign {fifo_lost_enable, single_frame_tx_enable, single_frame_rx_enable, full_irq_enable, tx_irq_enable,
    rx_irq_enable} = ien;
  assign {gw_fifo_overwrite_enable, queue_lost_enable, queue_overwrite_enable, payload_overwrite_enable,
    length_code_error_enable} = gen;
  assign {gw_fifo_overwrite_status, queue_lost_status, queue_overwrite_status, payload_overwrite_status,
    length_code_error_status, history_overflow_status} = gst;
  assign {lost_flag_write_n, ftx_flag_write_n, frx_flag_write_n, full_flag_write_n, tx_flag_write_n,
    rx_flag_write_n} = wr_n;
  gw_fifo_irq dut (.*);
  gw_sw_model sw (.*);
  task chk(input logic [7:0] g, input logic [7:0] e);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task op(input logic [2:0] m, input int n);
    repeat (n) @(posedge ref_clk) ev <= m;
    @(posedge ref_clk) ev <= 3'h0;
    @(negedge ref_clk);
  endtask
  task clr(input logic [5:0] m);
    @(posedge ref_clk) clr_req <= m;
    @(posedge ref_clk) clr_req <= 6'h00;
    @(posedge ref_clk);
    @(negedge ref_clk);
  endtask
  task conclude;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial forever #50 ref_clk = ~ref_clk;
  initial begin
    repeat (2) @(posedge ref_clk);
    rstn <= 1'h1;
    op(3'h0, 2);
    op(3'h1, 1);
    chk(rx_irq_flag, 1'h0);
    chk(frx_irq_flag, 1'h1);
    op(3'h1, 1);
    chk(rx_irq_flag, 1'h1);
    clr(6'h01);
    chk(rx_irq_flag, 1'h0);
    @(posedge ref_clk) fill_threshold <= 3'h7;
    op(3'h1, 1);
    chk(rx_irq_flag, 1'h0);
    op(3'h1, 2);
    chk(rx_irq_flag, 1'h1);
    chk(full_irq_flag, 1'h1);
    chk(full_irq, 1'h1);
    chk(fifo_full, 1'h1);
    chk(single_frame_rx_irq, 1'h1);
    chk(msg_count, 8'h04);
    op(3'h4, 1);
    chk(global_error_irq, 1'h1);
    clr(6'h21);
    chk(global_error_irq, 1'h0);
    chk(msg_lost_flag, 1'h0);
    chk(rx_irq_flag, 1'h0);
    op(3'h2, 3);
    chk(tx_irq_flag, 1'h0);
    op(3'h2, 1);
    chk(tx_irq_flag, 1'h1);
    chk(tx_irq, 1'h1);
    chk(fifo_empty, 1'h1);
    chk(ftx_irq_flag, 1'h1);
    chk(single_frame_tx_irq, 1'h1);
    clr(6'h02);
    chk(tx_irq_flag, 1'h0);
    @(posedge ref_clk) irq_mode_select <= 1'h1;
    op(3'h1, 2);
    chk(rx_irq_flag, 1'h1);
    fork
      clr(6'h01);
      begin
        @(posedge ref_clk);
        op(3'h1, 1);
      end
    join
    chk(rx_irq_flag, 1'h1);
    op(3'h2, 1);
    chk(tx_irq_flag, 1'h1);
    @(posedge ref_clk) ien <= 6'h3E;
    @(negedge ref_clk) chk(rx_irq, 1'h0);
    chk(rx_irq_flag, 1'h1);
    @(posedge ref_clk) buffer_usage_enable <= 1'h0;
    for (int k = 0; k < 9 && fifo_empty !== 1'h1; k++) @(negedge ref_clk);
    chk(fifo_empty, 1'h1);
    chk(tx_irq_flag, 1'h1);
    chk(rx_irq_flag, 1'h1);
    op(3'h1, 1);
    chk(msg_count, 8'h00);
    for (int i = 0; i < 6; i++) begin
      @(posedge ref_clk) gst <= 6'h01 << i;
      gen <= 5'h00;
      @(negedge ref_clk) chk(global_error_irq, i == 0);
      @(posedge ref_clk) gen <= 5'h1F;
      @(negedge ref_clk) chk(global_error_irq, 1'h1);
    end
    conclude;
  end
endmodule
bind gw_fifo_irq gw_fifo_irq_sva sva_i (.*);
